// ### pkg/lb_pkg.sv
/*
  shared constants and types for both ends of the local bus.
  assumes one system clock at SYS_CLK_HZ shared by both ends.
*/
package lb_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned DATA_W = 64;
  localparam int unsigned LEN_W = 8;
  localparam int unsigned DMA_CH = 4;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned TGT_BTERM_EVERY = 4;
  // ----------------------------------------
  // line levels
  // ----------------------------------------
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_ACT = 1'b0;
  // ----------------------------------------
  // bus clock limits
  // ----------------------------------------
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned LCLK_MAX_HZ = 80_000_000;
  localparam int unsigned LCLK_MIN_HZ = 32_000_000;
  localparam int unsigned HALF_MIN_RAW = (SYS_CLK_HZ + 2 * LCLK_MAX_HZ - 1) / (2 * LCLK_MAX_HZ);
  localparam int unsigned HALF_MAX_RAW = SYS_CLK_HZ / (2 * LCLK_MIN_HZ);
  localparam int unsigned HALF_MIN_I = (HALF_MIN_RAW < 1) ? 1 : HALF_MIN_RAW;
  localparam int unsigned HALF_MAX_I = (HALF_MAX_RAW < HALF_MIN_I) ? HALF_MIN_I : HALF_MAX_RAW;
  localparam logic [DIV_W-1:0] HALF_MIN = DIV_W'(HALF_MIN_I);
  localparam logic [DIV_W-1:0] HALF_MAX = DIV_W'(HALF_MAX_I);
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_M_ADDR = 6'h02,
    ST_M_DATA = 6'h04,
    ST_S_WR = 6'h08,
    ST_S_RD_LOAD = 6'h10,
    ST_S_RD_SHOW = 6'h20
  } port_state_t;
  typedef enum logic [2:0] {
    HOLD_IDLE = 3'h1,
    HOLD_WAIT = 3'h2,
    HOLD_XFER = 3'h4
  } hold_state_t;
endpackage

// ### pkg/lb_if.sv
/*
  shared local bus: each end drives its own value and enable,
  the interface resolves the line levels. assumes one driver at a time.
*/
`timescale 1ns/1ps
interface lb_if #(
  parameter int unsigned DW = lb_pkg::DATA_W
) ();
  localparam int unsigned NB = DW / 8;
  // bridge drive
  logic [DW-1:0] br_ad_o;
  logic br_ad_oe;
  logic [NB-1:0] br_be_l_o;
  logic br_ads_l_o;
  logic br_blast_l_o;
  logic br_write_o;
  logic br_ctl_oe;
  logic br_ready_l_o;
  logic br_bterm_l_o;
  logic br_rsp_oe;
  // target drive
  logic [DW-1:0] tg_ad_o;
  logic tg_ad_oe;
  logic [NB-1:0] tg_be_l_o;
  logic tg_ads_l_o;
  logic tg_blast_l_o;
  logic tg_write_o;
  logic tg_ctl_oe;
  logic tg_ready_l_o;
  logic tg_bterm_l_o;
  logic tg_rsp_oe;
  // one-way lines
  logic [lb_pkg::DMA_CH-1:0] ldreq_l;
  logic [lb_pkg::DMA_CH-1:0] ldack_l;
  logic fhold;
  logic fholda;
  logic lreset_l;
  logic lclk;
  // resolved levels, undriven strobes and byte enables pulled to idle, lad and lwrite to 0
  logic [DW-1:0] lad;
  logic [NB-1:0] lbe_l;
  logic lads_l;
  logic lblast_l;
  logic lwrite;
  logic lready_l;
  logic lbterm_l;
  assign lad = br_ad_oe ? br_ad_o : (tg_ad_oe ? tg_ad_o : '0);
  assign lbe_l = br_ctl_oe ? br_be_l_o : (tg_ctl_oe ? tg_be_l_o : '1);
  assign lads_l = br_ctl_oe ? br_ads_l_o : (tg_ctl_oe ? tg_ads_l_o : 1'b1);
  assign lblast_l = br_ctl_oe ? br_blast_l_o : (tg_ctl_oe ? tg_blast_l_o : 1'b1);
  assign lwrite = br_ctl_oe ? br_write_o : (tg_ctl_oe ? tg_write_o : 1'b0);
  assign lready_l = br_rsp_oe ? br_ready_l_o : (tg_rsp_oe ? tg_ready_l_o : 1'b1);
  assign lbterm_l = br_rsp_oe ? br_bterm_l_o : (tg_rsp_oe ? tg_bterm_l_o : 1'b1);

  modport bridge_mp (
    input lad, lbe_l, lads_l, lblast_l, lwrite, lready_l, lbterm_l, ldreq_l, fhold,
    output br_ad_o, br_ad_oe, br_be_l_o, br_ads_l_o, br_blast_l_o, br_write_o, br_ctl_oe,
    output br_ready_l_o, br_bterm_l_o, br_rsp_oe, ldack_l, fholda, lreset_l, lclk
  );
  modport target_mp (
    input lad, lbe_l, lads_l, lblast_l, lwrite, lready_l, lbterm_l, ldack_l, fholda, lreset_l, lclk,
    output tg_ad_o, tg_ad_oe, tg_be_l_o, tg_ads_l_o, tg_blast_l_o, tg_write_o, tg_ctl_oe,
    output tg_ready_l_o, tg_bterm_l_o, tg_rsp_oe, ldreq_l, fhold
  );
endinterface

// ### hdl/bridge_end.sv
/*
  bridge end of the local bus, plus lb_port, the master/slave engine
  used by both ends. assumes both ends run on sys_clk and the
  interface resolves the shared lines.
*/
// Operation
// - shared multiplexed address/data, 32 or 64 bits
// - either end may master the bus
// - bridge decouples local bus from host side
// - master strobes address phase low
// - target burst-terminate forces new address phase
// - word completes only when ready asserted; lb_port also completes it on burst-terminate alone
// - direction high write, low read
// - target drives four DMA requests
// - bridge drives four DMA acknowledges
// - bridge drives bus clock, all synchronous
// - bus clock at most 80 MHz
// - bus clock never below 32 MHz; at 50 MHz sys_clk the clamp gives half=1, a 25 MHz bus clock
// - software setting selects bus clock; here every setting is clamped to half=1
`timescale 1ns/1ps
module lb_port #(
  parameter int unsigned DW = lb_pkg::DATA_W,
  parameter int unsigned LW = lb_pkg::LEN_W,
  parameter int unsigned BTERM_EVERY = 0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sync_clr,
  // resolved bus levels
  input wire logic [DW-1:0] ad_i,
  input wire logic [DW/8-1:0] be_l_i,
  input wire logic ads_l_i,
  input wire logic blast_l_i,
  input wire logic write_i,
  input wire logic ready_l_i,
  input wire logic bterm_l_i,
  // own bus drive
  output logic [DW-1:0] ad_o,
  output logic ad_oe,
  output logic [DW/8-1:0] be_l_o,
  output logic ads_l_o,
  output logic blast_l_o,
  output logic write_o,
  output logic ctl_oe,
  output logic ready_l_o,
  output logic bterm_l_o,
  output logic rsp_oe,
  // master command port
  input wire logic m_start,
  input wire logic m_write,
  input wire logic [DW-1:0] m_addr,
  input wire logic [LW-1:0] m_len,
  input wire logic [DW/8-1:0] m_be_l,
  input wire logic [DW-1:0] m_wdata,
  output logic m_busy,
  output logic [LW-1:0] m_idx,
  output logic [DW-1:0] m_rdata,
  output logic m_rvalid,
  output logic m_done,
  output logic port_idle,
  // slave access port
  input wire logic s_en,
  input wire logic [DW-1:0] s_rdata,
  output logic [DW-1:0] s_addr,
  output logic s_we,
  output logic [DW-1:0] s_wdata,
  output logic [DW/8-1:0] s_be_l
);
  import lb_pkg::*;
  localparam logic [DW-1:0] STEP = DW'(DW / 8);
  localparam logic [LW-1:0] ONE = LW'(1);
  localparam logic [LW-1:0] TERM_AT = LW'(BTERM_EVERY - 1);
  localparam logic USE_TERM = (BTERM_EVERY != 0);

  port_state_t state;
  port_state_t next_state;
  logic [DW-1:0] maddr;
  logic [LW-1:0] remain;
  logic [LW-1:0] scount;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic m_word_done = (state == ST_M_DATA) && (!ready_l_i || !bterm_l_i);
  wire logic m_last = (remain == ONE);
  wire logic s_hit = (state == ST_IDLE) && s_en && !ads_l_i;
  wire logic s_end = !blast_l_i || !bterm_l_o;
  wire logic load_first = (state == ST_IDLE) && (next_state == ST_M_ADDR);
  wire logic restart = (state == ST_M_DATA) && (next_state == ST_M_ADDR);
  wire logic wd_load = (next_state == ST_M_DATA) && ((state == ST_M_ADDR) || m_word_done);
  wire logic nx_m = (next_state == ST_M_ADDR) || (next_state == ST_M_DATA);
  wire logic nx_s = (next_state == ST_S_WR) || (next_state == ST_S_RD_LOAD) || (next_state == ST_S_RD_SHOW);
  wire logic resp_on = (next_state == ST_S_WR) || (next_state == ST_S_RD_SHOW);
  wire logic [LW-1:0] first_len = (m_len == '0) ? ONE : m_len;
  wire logic [LW-1:0] remain_nx = load_first ? first_len : (m_word_done ? remain - ONE : remain);
  wire logic [LW-1:0] scount_nx = scount + ONE;
  wire logic [LW-1:0] widx = (state == ST_IDLE) ? '0 : ((state == ST_S_WR) ? scount_nx : scount);
  wire logic is_term = USE_TERM && (widx == TERM_AT);
  wire logic [DW-1:0] next_ad = load_first ? m_addr :
                                restart ? maddr + STEP :
                                wd_load ? m_wdata :
                                (next_state == ST_S_RD_SHOW) ? s_rdata : ad_o;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // a slave hit wins over a local start; the tops keep the two exclusive
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (s_hit) begin
          next_state = write_i ? ST_S_WR : ST_S_RD_LOAD;
        end else if (m_start) begin
          next_state = ST_M_ADDR;
        end
      end
      ST_M_ADDR: next_state = ST_M_DATA;
      ST_M_DATA: begin
        if (m_word_done) begin
          next_state = m_last ? ST_IDLE : (!bterm_l_i ? ST_M_ADDR : ST_M_DATA);
        end
      end
      ST_S_WR: next_state = s_end ? ST_IDLE : ST_S_WR;
      ST_S_RD_LOAD: next_state = ST_S_RD_SHOW;
      ST_S_RD_SHOW: next_state = s_end ? ST_IDLE : ST_S_RD_LOAD;
      default: next_state = ST_IDLE;
    endcase
    if (sync_clr) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // master bookkeeping
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      maddr <= '0;
      remain <= '0;
      m_idx <= '0;
      write_o <= 1'b0;
      be_l_o <= '1;
    end else begin
      if (load_first) begin
        maddr <= m_addr;
        write_o <= m_write;
        be_l_o <= m_be_l;
      end else if (m_word_done) begin
        maddr <= maddr + STEP;
      end
      remain <= remain_nx;
      m_idx <= load_first ? '0 : (wd_load ? m_idx + ONE : m_idx);
    end
  end

  // ----------------------------------------
  // line drive, all registered from the next state
  // ----------------------------------------
  // read turnaround: the slave waits one load cycle before driving
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ad_o <= '0;
      ad_oe <= 1'b0;
      ctl_oe <= 1'b0;
      ads_l_o <= LINE_IDLE;
      blast_l_o <= LINE_IDLE;
      rsp_oe <= 1'b0;
      ready_l_o <= LINE_IDLE;
      bterm_l_o <= LINE_IDLE;
      m_busy <= 1'b0;
      port_idle <= 1'b1;
    end else begin
      ad_o <= next_ad;
      ad_oe <= (next_state == ST_M_ADDR) || ((next_state == ST_M_DATA) && write_o) ||
               (next_state == ST_S_RD_SHOW);
      ctl_oe <= nx_m;
      ads_l_o <= (next_state == ST_M_ADDR) ? LINE_ACT : LINE_IDLE;
      blast_l_o <= ((next_state == ST_M_DATA) && (remain_nx == ONE)) ? LINE_ACT : LINE_IDLE;
      rsp_oe <= nx_s;
      ready_l_o <= (resp_on && !is_term) ? LINE_ACT : LINE_IDLE;
      bterm_l_o <= (resp_on && is_term) ? LINE_ACT : LINE_IDLE;
      m_busy <= nx_m;
      port_idle <= (next_state == ST_IDLE);
    end
  end

  // ----------------------------------------
  // user-side results
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_rdata <= '0;
      m_rvalid <= 1'b0;
      m_done <= 1'b0;
      s_addr <= '0;
      s_we <= 1'b0;
      s_wdata <= '0;
      s_be_l <= '1;
      scount <= '0;
    end else begin
      m_rvalid <= m_word_done && !write_o;
      m_rdata <= (m_word_done && !write_o) ? ad_i : m_rdata;
      m_done <= m_word_done && m_last;
      s_we <= (state == ST_S_WR);
      s_wdata <= (state == ST_S_WR) ? ad_i : s_wdata;
      s_be_l <= (state == ST_S_WR) ? be_l_i : s_be_l;
      s_addr <= s_hit ? ad_i : ((s_we || (state == ST_S_RD_SHOW)) ? s_addr + STEP : s_addr);
      scount <= s_hit ? '0 : (((state == ST_S_WR) || (state == ST_S_RD_SHOW)) ? scount_nx : scount);
    end
  end
endmodule

module bridge_end #(
  parameter int unsigned DW = lb_pkg::DATA_W,
  parameter int unsigned LW = lb_pkg::LEN_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // local bus
  lb_if.bridge_mp bus,
  // host-side command port
  input wire logic cmd_start,
  input wire logic cmd_write,
  input wire logic [DW-1:0] cmd_addr,
  input wire logic [LW-1:0] cmd_len,
  input wire logic [DW/8-1:0] cmd_be_l,
  input wire logic [DW-1:0] cmd_wdata,
  output logic cmd_busy,
  output logic [LW-1:0] cmd_idx,
  output logic [DW-1:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_done,
  // access port for target-mastered transfers
  input wire logic [DW-1:0] acc_rdata,
  output logic [DW-1:0] acc_addr,
  output logic acc_we,
  output logic [DW-1:0] acc_wdata,
  output logic [DW/8-1:0] acc_be_l,
  // board control
  input wire logic [lb_pkg::DIV_W-1:0] lclk_half,
  input wire logic tgt_reset_req,
  input wire logic [lb_pkg::DMA_CH-1:0] dma_en,
  output logic [lb_pkg::DMA_CH-1:0] dma_pending,
  output logic hold_granted
);
  import lb_pkg::*;
  logic [DIV_W-1:0] div_cnt;
  logic eng_idle;

  // ----------------------------------------
  // bus clock generator
  // ----------------------------------------
  // setting clamped to HALF_MIN..HALF_MAX; at 50 MHz both are 1, so the bus clock is fixed at 25 MHz
  wire logic [DIV_W-1:0] half_sel = (lclk_half < HALF_MIN) ? HALF_MIN :
                                    (lclk_half > HALF_MAX) ? HALF_MAX : lclk_half;
  wire logic div_wrap = (div_cnt >= half_sel - DIV_W'(1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      bus.lclk <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
      bus.lclk <= div_wrap ? !bus.lclk : bus.lclk;
    end
  end

  // ----------------------------------------
  // arbitration, dma, target reset
  // ----------------------------------------
  // grant only when our own engine is idle and not about to start
  wire logic grant_nx = bus.fhold && (bus.fholda || (eng_idle && !cmd_start));
  wire logic local_start = cmd_start && !bus.fholda;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.fholda <= 1'b0;
      hold_granted <= 1'b0;
      bus.ldack_l <= '1;
      dma_pending <= '0;
      bus.lreset_l <= LINE_ACT;
    end else begin
      bus.fholda <= grant_nx;
      hold_granted <= grant_nx;
      bus.ldack_l <= ~(~bus.ldreq_l & dma_en);
      dma_pending <= ~bus.ldreq_l;
      bus.lreset_l <= tgt_reset_req ? LINE_ACT : LINE_IDLE;
    end
  end

  // ----------------------------------------
  // engine
  // ----------------------------------------
  lb_port #(
    .DW(DW),
    .LW(LW),
    .BTERM_EVERY(0)
  ) u_port (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sync_clr(1'b0),
    .ad_i(bus.lad),
    .be_l_i(bus.lbe_l),
    .ads_l_i(bus.lads_l),
    .blast_l_i(bus.lblast_l),
    .write_i(bus.lwrite),
    .ready_l_i(bus.lready_l),
    .bterm_l_i(bus.lbterm_l),
    .ad_o(bus.br_ad_o),
    .ad_oe(bus.br_ad_oe),
    .be_l_o(bus.br_be_l_o),
    .ads_l_o(bus.br_ads_l_o),
    .blast_l_o(bus.br_blast_l_o),
    .write_o(bus.br_write_o),
    .ctl_oe(bus.br_ctl_oe),
    .ready_l_o(bus.br_ready_l_o),
    .bterm_l_o(bus.br_bterm_l_o),
    .rsp_oe(bus.br_rsp_oe),
    .m_start(local_start),
    .m_write(cmd_write),
    .m_addr(cmd_addr),
    .m_len(cmd_len),
    .m_be_l(cmd_be_l),
    .m_wdata(cmd_wdata),
    .m_busy(cmd_busy),
    .m_idx(cmd_idx),
    .m_rdata(cmd_rdata),
    .m_rvalid(cmd_rvalid),
    .m_done(cmd_done),
    .port_idle(eng_idle),
    .s_en(bus.fholda),
    .s_rdata(acc_rdata),
    .s_addr(acc_addr),
    .s_we(acc_we),
    .s_wdata(acc_wdata),
    .s_be_l(acc_be_l)
  );
endmodule

// ### hdl/target_end.sv
/*
  target end of the local bus: bus request, dma requests and the
  shared lb_port engine. assumes bridge_end.sv is compiled first.
*/
`timescale 1ns/1ps
module target_end #(
  parameter int unsigned DW = lb_pkg::DATA_W,
  parameter int unsigned LW = lb_pkg::LEN_W,
  parameter int unsigned BTERM_EVERY = lb_pkg::TGT_BTERM_EVERY
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // local bus
  lb_if.target_mp bus,
  // user command port
  input wire logic cmd_start,
  input wire logic cmd_write,
  input wire logic [DW-1:0] cmd_addr,
  input wire logic [LW-1:0] cmd_len,
  input wire logic [DW/8-1:0] cmd_be_l,
  input wire logic [DW-1:0] cmd_wdata,
  output logic cmd_busy,
  output logic [LW-1:0] cmd_idx,
  output logic [DW-1:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_done,
  // access port for bridge-mastered transfers
  input wire logic [DW-1:0] acc_rdata,
  output logic [DW-1:0] acc_addr,
  output logic acc_we,
  output logic [DW-1:0] acc_wdata,
  output logic [DW/8-1:0] acc_be_l,
  // dma and status
  input wire logic [lb_pkg::DMA_CH-1:0] dma_req,
  output logic [lb_pkg::DMA_CH-1:0] dma_ack,
  output logic in_reset
);
  import lb_pkg::*;
  hold_state_t hstate;
  logic start_q;
  logic eng_idle;
  logic eng_done;

  // ----------------------------------------
  // bus request sequencing
  // ----------------------------------------
  // the bridge reset line clears us synchronously; a fresh request waits for grant to fall
  wire logic clr = !bus.lreset_l;
  wire logic take = (hstate == HOLD_IDLE) && cmd_start && !bus.fholda && eng_idle;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hstate <= HOLD_IDLE;
      bus.fhold <= 1'b0;
      cmd_busy <= 1'b0;
      start_q <= 1'b0;
    end else if (clr) begin
      hstate <= HOLD_IDLE;
      bus.fhold <= 1'b0;
      cmd_busy <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (hstate)
        HOLD_IDLE: begin
          if (take) begin
            hstate <= HOLD_WAIT;
            bus.fhold <= 1'b1;
            cmd_busy <= 1'b1;
          end
        end
        HOLD_WAIT: begin
          if (bus.fholda) begin
            hstate <= HOLD_XFER;
            start_q <= 1'b1;
          end
        end
        HOLD_XFER: begin
          if (eng_done) begin
            hstate <= HOLD_IDLE;
            bus.fhold <= 1'b0;
            cmd_busy <= 1'b0;
          end
        end
        default: hstate <= HOLD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // dma and reset status
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.ldreq_l <= '1;
      dma_ack <= '0;
      in_reset <= 1'b1;
    end else begin
      bus.ldreq_l <= ~dma_req;
      dma_ack <= ~bus.ldack_l;
      in_reset <= clr;
    end
  end

  assign cmd_done = eng_done;

  // ----------------------------------------
  // engine
  // ----------------------------------------
  lb_port #(
    .DW(DW),
    .LW(LW),
    .BTERM_EVERY(BTERM_EVERY)
  ) u_port (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sync_clr(clr),
    .ad_i(bus.lad),
    .be_l_i(bus.lbe_l),
    .ads_l_i(bus.lads_l),
    .blast_l_i(bus.lblast_l),
    .write_i(bus.lwrite),
    .ready_l_i(bus.lready_l),
    .bterm_l_i(bus.lbterm_l),
    .ad_o(bus.tg_ad_o),
    .ad_oe(bus.tg_ad_oe),
    .be_l_o(bus.tg_be_l_o),
    .ads_l_o(bus.tg_ads_l_o),
    .blast_l_o(bus.tg_blast_l_o),
    .write_o(bus.tg_write_o),
    .ctl_oe(bus.tg_ctl_oe),
    .ready_l_o(bus.tg_ready_l_o),
    .bterm_l_o(bus.tg_bterm_l_o),
    .rsp_oe(bus.tg_rsp_oe),
    .m_start(start_q),
    .m_write(cmd_write),
    .m_addr(cmd_addr),
    .m_len(cmd_len),
    .m_be_l(cmd_be_l),
    .m_wdata(cmd_wdata),
    .m_busy(),
    .m_idx(cmd_idx),
    .m_rdata(cmd_rdata),
    .m_rvalid(cmd_rvalid),
    .m_done(eng_done),
    .port_idle(eng_idle),
    .s_en(!bus.fholda),
    .s_rdata(acc_rdata),
    .s_addr(acc_addr),
    .s_we(acc_we),
    .s_wdata(acc_wdata),
    .s_be_l(acc_be_l)
  );
endmodule

// ### test/lb_asserts.sv
/*
  concurrent checks on the resolved local bus lines.
  assumes one sys_clk domain and lb_if levels fed in.
*/
`timescale 1ns/1ps
module lb_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // shared lines
  input wire logic lads_l,
  input wire logic lblast_l,
  input wire logic lready_l,
  input wire logic lbterm_l,
  input wire logic lwrite,
  input wire logic lclk,
  // one-way lines
  input wire logic [lb_pkg::DMA_CH-1:0] ldreq_l,
  input wire logic [lb_pkg::DMA_CH-1:0] ldack_l,
  input wire logic fhold,
  input wire logic fholda,
  // drive enables
  input wire logic br_ctl_oe,
  input wire logic tg_ctl_oe,
  input wire logic br_ad_oe,
  input wire logic tg_ad_oe
);
  import lb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // bus relations
  // ----------------------------------------
  // two drivers would fight on the control lines
  a_single_master: assert property (!(br_ctl_oe && tg_ctl_oe))
    else $error("both ends drive control");
  a_ads_by_master: assert property (!lads_l |-> br_ctl_oe || tg_ctl_oe)
    else $error("address strobe without master");
  a_blast_in_data: assert property (!lblast_l |-> lads_l)
    else $error("last word during address phase");
  a_ready_has_data: assert property (!lready_l || !lbterm_l |-> br_ad_oe || tg_ad_oe)
    else $error("ready with nobody on data");
  a_no_ready_addr: assert property (!lads_l |-> lready_l && lbterm_l)
    else $error("ready during address phase");
  a_ack_after_req: assert property ((~ldack_l & $past(ldreq_l)) == '0)
    else $error("dma ack without request");
  a_grant_needs_req: assert property (fholda |-> $past(fhold))
    else $error("grant without request");
  a_tgt_granted: assert property (tg_ctl_oe |-> fholda)
    else $error("target drives without grant");
  a_lclk_runs: assert property (1'b1 |=> lclk != $past(lclk))
    else $error("bus clock did not toggle");
  a_dir_held: assert property (br_ctl_oe && $past(br_ctl_oe) |-> $stable(lwrite))
    else $error("direction changed in transfer");
  // main scenarios
  c_terminate: cover property (!lbterm_l);
  c_tgt_addr: cover property (tg_ctl_oe && !lads_l);
  c_dma_ack: cover property (ldack_l != '1);
endmodule

// ### test/bridge_target_local_bus_tb_top.sv
/*
  bench: bridge_end and target_end joined by lb_if, user ports driven here.
  assumes default lb_pkg widths and sys_clk at 50 MHz.
*/
`timescale 1ns/1ps
module bridge_target_local_bus_tb_top;
  import lb_pkg::*;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  localparam logic [63:0] K = 64'h5A5A_5A5A_0000_FFFF;
  logic sys_clk = 0, rst_b = 0, b_st = 0, t_st = 0, wr = 0, trr = 0;
  logic [63:0] ad = '0, base = '0;
  logic [7:0] len = '0, be = '0;
  logic [3:0] dreq = '0, den = '0, half = 4'h1;
  logic b_busy, t_busy, b_rv, t_rv, b_dn, t_dn, b_we, t_we, in_rst, grant;
  logic [7:0] b_idx, t_idx, b_bel, t_bel;
  logic [63:0] b_rd, t_rd, b_aa, t_aa, b_wd, t_wd;
  logic [3:0] pend, ack;
  int n_checks = 0, num_errors = 0, nwe = 0, nrv = 0, nads = 0, nbl = 0;
  bit gnt_seen = 0;
  lb_if bus ();
  // write data follows idx combinationally; read answers follow acc_addr
  bridge_end bridge_end_i (.sys_clk, .rst_b, .bus(bus), .cmd_start(b_st), .cmd_write(wr), .cmd_addr(ad),
    .cmd_len(len), .cmd_be_l(be), .cmd_wdata({8{b_idx}}), .cmd_busy(b_busy), .cmd_idx(b_idx),
    .cmd_rdata(b_rd), .cmd_rvalid(b_rv), .cmd_done(b_dn), .acc_rdata(b_aa ^ K), .acc_addr(b_aa),
    .acc_we(b_we), .acc_wdata(b_wd), .acc_be_l(b_bel), .lclk_half(half), .tgt_reset_req(trr),
    .dma_en(den), .dma_pending(pend), .hold_granted(grant));
  target_end target_end_i (.sys_clk, .rst_b, .bus(bus), .cmd_start(t_st), .cmd_write(wr), .cmd_addr(ad),
    .cmd_len(len), .cmd_be_l(be), .cmd_wdata({8{t_idx}}), .cmd_busy(t_busy), .cmd_idx(t_idx),
    .cmd_rdata(t_rd), .cmd_rvalid(t_rv), .cmd_done(t_dn), .acc_rdata(t_aa ^ K), .acc_addr(t_aa),
    .acc_we(t_we), .acc_wdata(t_wd), .acc_be_l(t_bel), .dma_req(dreq), .dma_ack(ack), .in_reset(in_rst));
  lb_asserts lb_asserts_i (.sys_clk, .rst_b, .lads_l(bus.lads_l), .lblast_l(bus.lblast_l),
    .lready_l(bus.lready_l), .lbterm_l(bus.lbterm_l), .lwrite(bus.lwrite), .lclk(bus.lclk),
    .ldreq_l(bus.ldreq_l), .ldack_l(bus.ldack_l), .fhold(bus.fhold), .fholda(bus.fholda),
    .br_ctl_oe(bus.br_ctl_oe), .tg_ctl_oe(bus.tg_ctl_oe), .br_ad_oe(bus.br_ad_oe), .tg_ad_oe(bus.tg_ad_oe));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watcher: every written word lands at base+k*8 with pattern k, every read word returns (base+k*8)^K, whichever end is slave
  always @(posedge sys_clk) begin
    if (!bus.lads_l) begin
      nads++;
      chk(bus.lwrite === wr && bus.lad[2:0] === 3'h0, "address phase");
    end
    if (!bus.lblast_l && !(bus.lready_l && bus.lbterm_l)) nbl++;
    if (b_we === 1'b1 || t_we === 1'b1) begin
      chk((b_we ? b_wd : t_wd) === {8{nwe[7:0]}}, "write data");
      chk((b_we ? {b_aa, b_bel} : {t_aa, t_bel}) === {base + 64'(nwe) * 8, be}, "write place");
      nwe++;
    end
    if (b_rv === 1'b1 || t_rv === 1'b1) begin
      chk((b_rv ? b_rd : t_rd) === ((base + 64'(nrv) * 8) ^ K), "read data");
      nrv++;
    end
    if (grant === 1'b1) gnt_seen = 1;
  end
  // one command on either end; start held until busy, then wait for done
  task automatic go(input bit tgt, input bit w, input logic [63:0] a, input logic [7:0] n);
    int k;
    int e;
    e = (n == 0) ? 1 : n;
    wr = w;
    ad = a;
    len = n;
    base = a;
    {nwe, nrv, nads, nbl} = '0;
    if (tgt) t_st = 1; else b_st = 1;
    for (k = 0; k < 50 && (tgt ? t_busy : b_busy) !== 1'b1; k++) #20;
    b_st = 0;
    t_st = 0;
    for (k = 0; k < 300 && (tgt ? t_dn : b_dn) !== 1'b1; k++) #20;
    #60;
    chk((w ? nwe : nrv) == e && nbl == 1, "word count");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bridge_wr;
    be = 8'h0F;
    go(0, 1, 64'h0000_0000_0000_0100, 8'h02);
    chk(nads == 1, "one address phase");
    go(0, 1, 64'h0000_0000_0000_0008, 8'h00);
    go(0, 1, 64'h0000_0000_0000_0200, 8'h05);
    chk(nads == 2, "write resumes after terminate");
    $display("test bridge write done");
  endtask
  // six words cross the terminate point after the fourth
  task automatic t_bridge_rd;
    go(0, 0, 64'h0000_0000_0000_2000, 8'h06);
    chk(nads == 2, "new address after terminate");
    $display("test bridge read done");
  endtask
  task automatic t_target_xfer;
    gnt_seen = 0;
    be = 8'hA0;
    go(1, 1, 64'h0000_0000_0000_0300, 8'h03);
    chk(gnt_seen && bus.fhold === 1'b0 && bus.fholda === 1'b0, "hold handshake");
    go(1, 0, 64'h0000_0000_0000_0048, 8'h01);
    $display("test target transfers done");
  endtask
  // each channel masked first, then enabled, then withdrawn
  task automatic t_dma;
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 4'(1 << i);
      den = 4'h0;
      dreq = m;
      #80;
      chk(ack === 4'h0 && pend === m && bus.ldreq_l === ~m, "dma masked");
      den = 4'hF;
      #80;
      chk(ack === m && bus.ldack_l === ~m, "dma ack");
      dreq = 4'h0;
      #80;
    end
    $display("test dma done");
  endtask
  task automatic t_reset;
    trr = 1;
    #60;
    chk(bus.lreset_l === 1'b0 && in_rst === 1'b1, "target held");
    trr = 0;
    #60;
    chk(in_rst === 1'b0, "target released");
    $display("test target reset done");
  endtask
  // an out-of-band setting must still give a toggling bus clock
  task automatic t_lclk;
    logic v;
    for (int s = 0; s < 16; s += 15) begin
      half = 4'(s);
      #100;
      v = bus.lclk;
      #(20 * ((s == 0) ? HALF_MIN : HALF_MAX));
      chk(bus.lclk !== v, "bus clock clamp");
    end
    half = 4'h1;
    $display("test bus clock done");
  endtask
  // main sequence; inputs move 1 ns after rising edges
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1;
    #100;
    t_bridge_wr();
    t_bridge_rd();
    t_target_xfer();
    t_dma();
    t_reset();
    t_lclk();
    report_and_stop();
  end
  // the tests need about 3 us; a hang is cut at 20 us
  initial begin
    #20000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    report_and_stop();
  end
endmodule
